// *** verilog/aetr_pkg.sv ***
// Package of register offsets, field positions, reset values and types for the charger register bank.
package aetr_pkg;

	// Register offsets on the host register port.
	localparam logic [7:0] AETR_OFS_CHAN_EN = 8'h58;
	localparam logic [7:0] AETR_OFS_DERATE = 8'h61;
	localparam logic [7:0] AETR_OFS_COLD = 8'h62;
	localparam logic [7:0] AETR_OFS_COOL = 8'h63;
	localparam logic [7:0] AETR_OFS_WARM = 8'h64;
	localparam logic [7:0] AETR_OFS_HOT = 8'h65;
	localparam logic [7:0] AETR_OFS_PART_ID = 8'h6f;

	// Reset values.
	localparam logic [7:0] AETR_RST_CHAN_EN = 8'h00;
	localparam logic [7:0] AETR_RST_DERATE = 8'h34;
	localparam logic [7:0] AETR_RST_COLD = 8'h7c;
	localparam logic [7:0] AETR_RST_COOL = 8'h6d;
	localparam logic [7:0] AETR_RST_WARM = 8'h38;
	localparam logic [7:0] AETR_RST_HOT = 8'h27;

	// Part code is an arbitrary neutral value.
	localparam logic [7:0] AETR_PART_CODE = 8'h5a;

	// Channel enable bit positions.
	localparam int AETR_BIT_IN_CUR = 7;
	localparam int AETR_BIT_RAIL = 6;
	localparam int AETR_BIT_CHG_CUR = 5;
	localparam int AETR_BIT_IN_VOLT = 4;
	localparam int AETR_BIT_VBAT = 3;
	localparam int AETR_BIT_THERM = 2;
	localparam int AETR_BIT_AUX = 1;

	// Derate field positions.
	localparam int AETR_VRED_HI = 6;
	localparam int AETR_VRED_LO = 4;
	localparam int AETR_ISCL_HI = 2;
	localparam int AETR_ISCL_LO = 0;

	// Threshold weighting: LSB weight in microvolts, MSB 600 mV.
	localparam int AETR_THERM_LSB_UV = 4688;
	localparam int AETR_VRED_STEP_MV = 50;
	localparam logic [3:0] AETR_ISCL_EIGHTHS = 4'h8;

	typedef enum logic [2:0] {
		AETR_REG_COLD,
		AETR_REG_COOL,
		AETR_REG_NORMAL,
		AETR_REG_WARM,
		AETR_REG_HOT
	} aetr_region_type;

	// Individual measurement channel enables.
	typedef struct packed {
		logic input_current_meas_enable;
		logic system_rail_meas_enable;
		logic charge_current_meas_enable;
		logic input_voltage_meas_enable;
		logic battery_voltage_meas_enable;
		logic thermistor_meas_enable;
		logic aux_input_meas_enable;
	} aetr_chan_en_type;

	// Four region thresholds, in thermistor sense codes.
	typedef struct packed {
		logic [7:0] cold_threshold_value;
		logic [7:0] cool_threshold_value;
		logic [7:0] warm_threshold_value;
		logic [7:0] hot_threshold_value;
	} aetr_thresh_type;

	// Derating applied to the charger loops.
	typedef struct packed {
		logic [8:0] voltage_drop_mv;
		logic [3:0] current_eighths;
	} aetr_derate_type;

endpackage

// *** verilog/aetr_region_classify.sv ***
// Thermistor region classifier comparing a sense code against four thresholds.
`timescale 1ns/1ps
module aetr_region_classify
	import aetr_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Measurement and thresholds
	input wire logic [7:0] sense_code_in,
	input wire logic sense_valid_in,
	input wire aetr_thresh_type thresh_in,
	// Region result
	output aetr_region_type region_out
);

	// An NTC below ground bias gives a higher voltage when colder.
	wire aetr_region_type region_now;
	assign region_now = (sense_code_in >= thresh_in.cold_threshold_value) ? AETR_REG_COLD :
		(sense_code_in >= thresh_in.cool_threshold_value) ? AETR_REG_COOL :
		(sense_code_in <= thresh_in.hot_threshold_value) ? AETR_REG_HOT :
		(sense_code_in <= thresh_in.warm_threshold_value) ? AETR_REG_WARM :
		AETR_REG_NORMAL; // R08 R14

	// The region holds its last value while no fresh sample arrives.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			region_out <= AETR_REG_NORMAL;
		end else if (sense_valid_in) begin
			region_out <= region_now; // R14
		end
	end

endmodule

// *** verilog/aetr_derate_calc.sv ***
// Converts derating codes and the present region into applied derating.
`timescale 1ns/1ps
module aetr_derate_calc
	import aetr_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Settings and region
	input wire logic [2:0] warm_voltage_reduction_in,
	input wire logic [2:0] thermal_current_scale_in,
	input wire aetr_region_type region_in,
	// Applied derating
	output aetr_derate_type derate_out
);

	function automatic logic [8:0] volt_drop(input logic [2:0] code);
		volt_drop = 9'(code * AETR_VRED_STEP_MV);
	endfunction

	function automatic logic [3:0] cur_eighths(input logic [2:0] code);
		cur_eighths = AETR_ISCL_EIGHTHS - {1'b0, code};
	endfunction

	wire logic in_warm;
	wire logic in_cool_or_warm;
	assign in_warm = (region_in == AETR_REG_WARM);
	assign in_cool_or_warm = in_warm || (region_in == AETR_REG_COOL);

	// Current is cut in both cool and warm; voltage only in warm.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			derate_out <= '{voltage_drop_mv: 9'h000, current_eighths: AETR_ISCL_EIGHTHS};
		end else begin
			derate_out.voltage_drop_mv <= in_warm ?
				volt_drop(warm_voltage_reduction_in) : 9'h000; // R06 R14
			derate_out.current_eighths <= in_cool_or_warm ?
				cur_eighths(thermal_current_scale_in) : AETR_ISCL_EIGHTHS; // R07 R14
		end
	end

endmodule

// *** verilog/aetr_regs.sv ***
// Converter channel enable, thermal derating and thermistor threshold register bank.
// Function
// R01 - Bit 7 enables input current conversions; zero disables them.
// R02 - Bit 6 gates system rail, bit 5 charge current measurement.
// R03 - Bit 4 gates input voltage, bit 3 battery voltage measurement.
// R04 - Bit 2 gates thermistor, bit 1 auxiliary input measurement.
// R05 - Channel enable register at 0x58 resets to zero; bit 0 reserved read-write.
// R06 - Warm voltage reduction bits 6-4, code times 50 mV, reset 011.
// R07 - Current scale bits 2-0, each code removes one eighth, reset 100.
// R08 - Thresholds binary weighted, LSB 4.688 mV up to MSB 600 mV.
// R09 - Cold threshold at 0x62 is read-write, resets to 0x7C.
// R10 - Cool threshold at 0x63 is read-write, resets to 0x6D.
// R11 - Warm threshold at 0x64 is read-write, resets to 0x38.
// R12 - Hot threshold at 0x65 is read-write, resets to 0x27.
// R13 - Read-only part code at 0x6F ignores writes.
// R14 - Classify thermistor into five regions and apply derating there.
`timescale 1ns/1ps
module aetr_regs
	import aetr_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Register port from the host serial interface
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// Thermistor measurement from the converter
	input wire logic [7:0] therm_code_in,
	input wire logic therm_valid_in,
	// Channel enables to the converter sequencer
	output aetr_chan_en_type chan_en_out,
	// Thermal state and derating to the charger loops
	output aetr_region_type region_out,
	output aetr_derate_type derate_out
);

	logic [7:0] chan_en_reg;
	logic [7:0] derate_reg;
	logic [7:0] cold_reg;
	logic [7:0] cool_reg;
	logic [7:0] warm_reg;
	logic [7:0] hot_reg;
	logic [7:0] rdata_next;

	wire logic wr_chan_en;
	wire logic wr_derate;
	wire logic wr_cold;
	wire logic wr_cool;
	wire logic wr_warm;
	wire logic wr_hot;
	assign wr_chan_en = reg_wr_in && (reg_addr_in == AETR_OFS_CHAN_EN); // R05
	assign wr_derate = reg_wr_in && (reg_addr_in == AETR_OFS_DERATE);
	assign wr_cold = reg_wr_in && (reg_addr_in == AETR_OFS_COLD); // R09
	assign wr_cool = reg_wr_in && (reg_addr_in == AETR_OFS_COOL); // R10
	assign wr_warm = reg_wr_in && (reg_addr_in == AETR_OFS_WARM); // R11
	assign wr_hot = reg_wr_in && (reg_addr_in == AETR_OFS_HOT); // R12

	// Every bit of these registers is read-write, reserved bits included.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			chan_en_reg <= AETR_RST_CHAN_EN; // R05
			derate_reg <= AETR_RST_DERATE; // R06 R07
			cold_reg <= AETR_RST_COLD; // R09
			cool_reg <= AETR_RST_COOL; // R10
			warm_reg <= AETR_RST_WARM; // R11
			hot_reg <= AETR_RST_HOT; // R12
		end else begin
			if (wr_chan_en) chan_en_reg <= reg_wdata_in;
			if (wr_derate) derate_reg <= reg_wdata_in;
			if (wr_cold) cold_reg <= reg_wdata_in;
			if (wr_cool) cool_reg <= reg_wdata_in;
			if (wr_warm) warm_reg <= reg_wdata_in;
			if (wr_hot) hot_reg <= reg_wdata_in;
		end
	end

	// Unmapped offsets read zero; the part code has no write path at all.
	always_comb begin
		case (reg_addr_in)
			AETR_OFS_CHAN_EN: rdata_next = chan_en_reg;
			AETR_OFS_DERATE: rdata_next = derate_reg;
			AETR_OFS_COLD: rdata_next = cold_reg;
			AETR_OFS_COOL: rdata_next = cool_reg;
			AETR_OFS_WARM: rdata_next = warm_reg;
			AETR_OFS_HOT: rdata_next = hot_reg;
			AETR_OFS_PART_ID: rdata_next = AETR_PART_CODE; // R13
			default: rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in) reg_rdata_out <= rdata_next;
		end
	end

	// Enables are registered copies so the sequencer sees a clean level.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			chan_en_out <= '0;
		end else begin
			chan_en_out.input_current_meas_enable <= chan_en_reg[AETR_BIT_IN_CUR]; // R01
			chan_en_out.system_rail_meas_enable <= chan_en_reg[AETR_BIT_RAIL]; // R02
			chan_en_out.charge_current_meas_enable <= chan_en_reg[AETR_BIT_CHG_CUR]; // R02
			chan_en_out.input_voltage_meas_enable <= chan_en_reg[AETR_BIT_IN_VOLT]; // R03
			chan_en_out.battery_voltage_meas_enable <= chan_en_reg[AETR_BIT_VBAT]; // R03
			chan_en_out.thermistor_meas_enable <= chan_en_reg[AETR_BIT_THERM]; // R04
			chan_en_out.aux_input_meas_enable <= chan_en_reg[AETR_BIT_AUX]; // R04
		end
	end

	wire aetr_thresh_type thresh;
	assign thresh = '{cold_threshold_value: cold_reg, cool_threshold_value: cool_reg,
		warm_threshold_value: warm_reg, hot_threshold_value: hot_reg};

	// Samples only count while the thermistor channel is enabled.
	wire logic therm_sample;
	assign therm_sample = therm_valid_in && chan_en_reg[AETR_BIT_THERM]; // R04 R14

	aetr_region_classify u_classify (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.sense_code_in(therm_code_in),
		.sense_valid_in(therm_sample),
		.thresh_in(thresh),
		.region_out(region_out)
	);

	aetr_derate_calc u_derate (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.warm_voltage_reduction_in(derate_reg[AETR_VRED_HI:AETR_VRED_LO]),
		.thermal_current_scale_in(derate_reg[AETR_ISCL_HI:AETR_ISCL_LO]),
		.region_in(region_out),
		.derate_out(derate_out)
	);

endmodule

// *** test/aetr_regs_sva.sv ***
// Assertion checker watching the ports of the thermal register bank.
`timescale 1ns/1ps
module aetr_regs_chk
	import aetr_pkg::*;
(
	// Watched ports
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	input wire logic [7:0] therm_code_in,
	input wire logic therm_valid_in,
	input wire aetr_chan_en_type chan_en_out,
	input wire aetr_region_type region_out,
	input wire aetr_derate_type derate_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	AST_RVALID: assert property (reg_rd_in |=> reg_rvalid_out)
		else $error("read answer missing");
	AST_NO_RVALID: assert property (!reg_rd_in |=> !reg_rvalid_out)
		else $error("read answer without request");
	AST_RDATA_HOLD: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data moved without a read");
	AST_UNMAPPED: assert property (reg_rd_in && reg_addr_in == 8'h70 |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	AST_PART_CODE: assert property (reg_rd_in && reg_addr_in == 8'h6f |=> reg_rdata_out == AETR_PART_CODE)
		else $error("part code wrong");
	AST_CHAN: assert property (reg_wr_in && reg_addr_in == 8'h58 |-> ##2 chan_en_out == $past(reg_wdata_in[7:1], 2))
		else $error("channel enables do not follow write");
	AST_NORMAL: assert property (region_out == AETR_REG_NORMAL |=> derate_out == {9'h000, 4'h8})
		else $error("derating applied in normal region");
	AST_REGION_HOLD: assert property (!therm_valid_in |=> $stable(region_out))
		else $error("region moved without a sample");
endmodule
bind aetr_regs aetr_regs_chk u_chk (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
	.therm_code_in(therm_code_in), .therm_valid_in(therm_valid_in),
	.chan_en_out(chan_en_out), .region_out(region_out),
	.derate_out(derate_out));

// *** test/aetr_host_model.sv ***
// Behavioural host issuing register writes and reads on the register port.
`timescale 1ns/1ps
module aetr_host_model (
	// Clock
	input wire logic clk_in,
	// Read answer
	input wire logic [7:0] reg_rdata_in,
	input wire logic reg_rvalid_in,
	// Requests
	output logic [7:0] reg_addr_out,
	output logic [7:0] reg_wdata_out,
	output logic reg_wr_out,
	output logic reg_rd_out
);
	initial begin
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
	end
	// Released address and data are inverted so stale values never pass for a match.
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		reg_addr_out = a;
		reg_wdata_out = d;
		reg_wr_out = 1'b1;
		@(negedge clk_in);
		reg_wr_out = 1'b0;
		reg_addr_out = ~a;
		reg_wdata_out = ~d;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_in);
		reg_addr_out = a;
		reg_rd_out = 1'b1;
		@(negedge clk_in);
		reg_rd_out = 1'b0;
		reg_addr_out = ~a;
		d = reg_rvalid_in ? reg_rdata_in : 8'hxx;
	endtask
endmodule

// *** test/aetr_regs_bench.sv ***
// Self-checking bench for the thermal register bank.
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin failures++; \
	$display("unexpected %s exp %h got %h", n, e, a); end end
module aetr_regs_bench
	import aetr_pkg::*;
;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr, wdata, rdata, d;
	logic [7:0] therm_code = 8'h00;
	logic wr, rd, rvalid;
	logic therm_valid = 1'b0;
	aetr_chan_en_type chan_en;
	aetr_region_type region;
	aetr_derate_type derate;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	localparam logic [7:0] OFS [7] = '{8'h58, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h6f};
	localparam logic [7:0] RST [7] = '{8'h00, 8'h34, 8'h7c, 8'h6d, 8'h38, 8'h27, AETR_PART_CODE};
	aetr_host_model host (.clk_in(clk_in), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
		.reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));
	aetr_regs dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.therm_code_in(therm_code), .therm_valid_in(therm_valid), .chan_en_out(chan_en),
		.region_out(region), .derate_out(derate));
	always #10 clk_in = ~clk_in;
	task final_report;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			failures++;
			final_report;
		end
	end
	task t_reset;
		for (int i = 0; i < 7; i++) begin
			host.rd(OFS[i], d);
			`CHK("reset value", RST[i], d)
		end
		`CHK("chan_en after reset", 7'h00, chan_en)
		$display("test reset values done");
	endtask
	// One thermistor sample; region lands one edge after it, derating one edge later.
	task sample(input logic [7:0] c, input aetr_region_type r, input aetr_derate_type dr);
		@(negedge clk_in);
		therm_code = c;
		therm_valid = 1'b1;
		@(negedge clk_in);
		therm_valid = 1'b0;
		`CHK("region", r, region)
		@(negedge clk_in);
		`CHK("derate", dr, derate)
	endtask
	task t_region;
		host.wr(8'h58, 8'h04);
		sample(8'hff, AETR_REG_COLD, {9'h000, 4'h8});
		sample(8'h7c, AETR_REG_COLD, {9'h000, 4'h8});
		sample(8'h7b, AETR_REG_COOL, {9'h000, 4'h4});
		sample(8'h6d, AETR_REG_COOL, {9'h000, 4'h4});
		sample(8'h6c, AETR_REG_NORMAL, {9'h000, 4'h8});
		sample(8'h38, AETR_REG_WARM, {9'h096, 4'h4});
		sample(8'h28, AETR_REG_WARM, {9'h096, 4'h4});
		sample(8'h27, AETR_REG_HOT, {9'h000, 4'h8});
		host.wr(8'h61, 8'h77);
		sample(8'h30, AETR_REG_WARM, {9'h15e, 4'h1});
		host.wr(8'h58, 8'h00);
		sample(8'h10, AETR_REG_WARM, {9'h15e, 4'h1});
		$display("test regions done");
	endtask
	task t_rw;
		for (int i = 0; i < 7; i++) begin
			host.wr(OFS[i], ~RST[i]);
			host.rd(OFS[i], d);
			`CHK("readback", (i == 6) ? AETR_PART_CODE : ~RST[i], d)
		end
		for (int b = 0; b < 8; b++) begin
			host.wr(8'h58, 8'h01 << b);
			@(negedge clk_in);
			`CHK("chan_en", 7'((8'h01 << b) >> 1), chan_en)
			host.rd(8'h58, d);
			`CHK("chan_en readback", 8'h01 << b, d)
		end
		host.wr(8'h70, 8'hff);
		host.rd(8'h70, d);
		`CHK("unmapped read", 8'h00, d)
		$display("test read write done");
	endtask
	initial begin
		repeat (20) @(negedge clk_in);
		rst_in = 1'b0;
		t_reset;
		t_region;
		t_rw;
		final_report;
	end
endmodule
